/* src/virtual_icache_dcache.sv */
`timescale 1ns/1ps
`include "vcache_cfg.svh"
module virtual_icache_dcache
	import vcache_pkg::*;
#(
	parameter int SETS = 16,
	parameter int WAYS = 32
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic if_req,
	input wire logic [31:0] if_va,
	input wire logic [31:0] if_pa,
	input wire logic if_cacheable,
	output logic if_ack,
	output logic [31:0] if_rdata,
	input wire logic d_req,
	input wire logic d_we,
	input wire logic [3:0] d_be,
	input wire logic [31:0] d_va,
	input wire logic [31:0] d_pa,
	input wire logic [31:0] d_wdata,
	input wire logic d_cacheable,
	input wire logic d_bufferable,
	output logic d_ack,
	output logic [31:0] d_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [3:0] mem_words,
	output logic [31:0] mem_wdata,
	output logic [3:0] mem_be,
	output logic mem_bufferable,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	localparam int SW = $clog2(SETS);
	localparam int WW = $clog2(WAYS);
	localparam int TAGW = 27 - SW;
	localparam int LINES = SETS * WAYS;

	if ((1 << SW) != SETS || (1 << WW) != WAYS || SW < 1 || SW > 20) begin : g_bad
		$error("virtual_icache_dcache: SETS and WAYS must be powers of two");
	end

	function automatic logic [SW+WW+2:0] widx(input logic [SW-1:0] s, input logic [WW-1:0] w,
		input logic [2:0] k);
		return {s, w, k};
	endfunction

	function automatic logic [SW+WW-1:0] lidx(input logic [SW-1:0] s, input logic [WW-1:0] w);
		return {s, w};
	endfunction

	// ********************************
	// Storage
	// ********************************
	logic [31:0] idata [LINES*8];
	logic [31:0] ddata [LINES*8];
	logic [26:0] dphys [LINES];
	logic [LINES-1:0] dlo_q;
	logic [LINES-1:0] dhi_q;

	fsm_state_t st_q;
	logic [2:0] cnt_q;
	logic [2:0] last_q;
	logic [2:0] word_q;
	logic [SW-1:0] set_q;
	logic [WW-1:0] way_q;
	logic [26:0] pa_q;
	logic wb_op_q;
	logic [31:0] cap_q;
	logic op_done_q;
	logic if_ack_q;
	logic [31:0] if_rdata_q;
	logic d_ack_q;
	logic [31:0] d_rdata_q;
	logic mem_req_q;
	logic mem_we_q;
	logic [31:0] mem_addr_q;
	logic [3:0] mem_words_q;
	logic [31:0] mem_wdata_q;
	logic [3:0] mem_be_q;
	logic mem_buf_q;

	logic mmu_en;
	logic dc_en;
	logic ic_en;
	logic op_valid;
	logic [2:0] op_code;
	logic [31:0] op_va;
	logic dc_hit_raw;
	logic [WW-1:0] dc_hway;
	logic [WW-1:0] dc_vway;
	logic dc_vvalid;
	logic ic_hit;
	logic [WW-1:0] ic_hway;
	logic [WW-1:0] ic_vway;

	// ********************************
	// Request selection and lookup
	// ********************************
	wire idle = (st_q == ST_IDLE);
	wire op_act = idle & op_valid & ~op_done_q;
	wire d_go = idle & ~op_act & d_req & ~d_ack_q;
	wire i_go = idle & ~op_act & ~d_go & if_req & ~if_ack_q;
	wire [31:0] dk_va = op_act ? op_va : d_va;
	wire [SW-1:0] dk_set = dk_va[SW+4:5];
	wire [TAGW-1:0] dk_tag = dk_va[31:SW+5];
	wire [SW-1:0] ik_set = if_va[SW+4:5];
	wire [TAGW-1:0] ik_tag = if_va[31:SW+5];

	// Search needs mmu_en but ignores dc_en and the cacheable attribute
	wire dc_hit = mmu_en & dc_hit_raw;
	wire [SW+WW-1:0] d_hline = lidx(dk_set, dc_hway);
	wire [SW+WW-1:0] d_vline = lidx(dk_set, dc_vway);
	wire hit_lo = dlo_q[d_hline];
	wire hit_hi = dhi_q[d_hline];
	wire vic_lo = dc_vvalid & dlo_q[d_vline];
	wire vic_hi = dc_vvalid & dhi_q[d_vline];

	wire op_fi = op_act & (op_code == `OP_FLUSH_I || op_code == `OP_FLUSH_ID);
	wire op_fd = op_act & (op_code == `OP_FLUSH_D || op_code == `OP_FLUSH_ID);
	wire op_fde = op_act & (op_code == `OP_FLUSH_DE) & dc_hit;
	wire op_cde = op_act & (op_code == `OP_CLEAN_DE) & dc_hit & (hit_lo | hit_hi);

	wire d_st_hit = d_go & dc_hit & d_we;
	wire d_alloc = d_go & ~dc_hit & ~d_we & mmu_en & dc_en & d_cacheable;
	wire i_alloc = i_go & ~ic_hit & ic_en & (~mmu_en | if_cacheable);
	wire i_single = i_go & ~ic_hit & ~i_alloc;
	wire d_single = d_go & ~dc_hit & ~d_alloc;

	// ********************************
	// External transfer start
	// ********************************
	// A dirty victim is copied back first; the miss then retries from idle
	wire start_wb = op_cde | (d_alloc & (vic_lo | vic_hi));
	wire start_dfill = d_alloc & ~vic_lo & ~vic_hi;
	wire start_fill = start_dfill | i_alloc;
	wire mem_ld = start_wb | start_fill | i_single | d_single;
	wire wb_lo = op_cde ? hit_lo : vic_lo;
	wire wb_hi = op_cde ? hit_hi : vic_hi;
	wire [WW-1:0] wb_way = op_cde ? dc_hway : dc_vway;
	wire [2:0] wb_k0 = wb_lo ? 3'h0 : `HALF_FIRST;
	wire [2:0] wb_last = wb_hi ? `LINE_LAST : `HALF_LAST;
	wire [3:0] wb_words = (wb_lo & wb_hi) ? `WORDS_LINE : `WORDS_HALF;
	wire [31:0] fill_addr = i_alloc ? {if_pa[31:5], 5'h00} : {d_pa[31:5], 5'h00};
	wire [31:0] one_addr = d_go ? {d_pa[31:2], 2'b00} : {if_pa[31:2], 2'b00};
	wire [31:0] ld_addr = start_wb ? {dphys[lidx(dk_set, wb_way)], wb_k0, 2'b00} :
		start_fill ? fill_addr : one_addr;
	wire [3:0] ld_words = start_wb ? wb_words : start_fill ? `WORDS_LINE : `WORDS_ONE;
	wire [2:0] ld_last = start_wb ? wb_last : start_fill ? `LINE_LAST : 3'h0;
	wire ld_we = start_wb | (d_single & d_we);
	wire ld_buf = start_wb | (d_single & d_bufferable);
	wire [31:0] ld_wdata = start_wb ? ddata[widx(dk_set, wb_way, wb_k0)] : d_wdata;

	wire beat = mem_req_q & mem_ack;
	wire last_beat = beat & (cnt_q == last_q);
	wire wb_end = (st_q == ST_WB) & last_beat;
	wire ifill_end = (st_q == ST_IFILL) & last_beat;
	wire dfill_end = (st_q == ST_DFILL) & last_beat;
	wire [31:0] fill_word = (cnt_q == word_q) ? mem_rdata : cap_q;

	// ********************************
	// Tag stores and control registers
	// ********************************
	way_lookup #(.SETS(SETS), .WAYS(WAYS), .TAGW(TAGW)) u_itags (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.lk_set(ik_set),
		.lk_tag(ik_tag),
		.hit(ic_hit),
		.hit_way(ic_hway),
		.vic_way(ic_vway),
		.vic_valid(),
		.wr_en(ifill_end),
		.wr_set(set_q),
		.wr_way(way_q),
		.wr_tag(ik_tag),
		.inv_one(1'b0),
		.inv_way(ic_hway),
		.inv_all(op_fi)
	);

	way_lookup #(.SETS(SETS), .WAYS(WAYS), .TAGW(TAGW)) u_dtags (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.lk_set(dk_set),
		.lk_tag(dk_tag),
		.hit(dc_hit_raw),
		.hit_way(dc_hway),
		.vic_way(dc_vway),
		.vic_valid(dc_vvalid),
		.wr_en(dfill_end),
		.wr_set(set_q),
		.wr_way(way_q),
		.wr_tag(dk_tag),
		.inv_one(op_fde),
		.inv_way(dc_hway),
		.inv_all(op_fd)
	);

	cache_ctrl_regs u_regs (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mmu_en(mmu_en),
		.dc_en(dc_en),
		.ic_en(ic_en),
		.op_valid(op_valid),
		.op_code(op_code),
		.op_va(op_va),
		.op_done(op_done_q),
		.engine_busy(~idle)
	);

	// ********************************
	// Data arrays
	// ********************************
	always_ff @(posedge clk_sys) begin
		if ((st_q == ST_IFILL) & beat) begin
			idata[widx(set_q, way_q, cnt_q)] <= mem_rdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if ((st_q == ST_DFILL) & beat) begin
			ddata[widx(set_q, way_q, cnt_q)] <= mem_rdata;
		end else if (d_st_hit) begin
			for (int b = 0; b < 4; b++) begin
				if (d_be[b]) begin
					ddata[widx(dk_set, dc_hway, d_va[4:2])][8*b+:8] <= d_wdata[8*b+:8];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dfill_end) begin
			dphys[lidx(set_q, way_q)] <= pa_q;
		end
	end

	// Whole invalidate drops dirty data on purpose; software cleans first
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dlo_q <= '0;
			dhi_q <= '0;
		end else if (op_fd) begin
			dlo_q <= '0;
			dhi_q <= '0;
		end else begin
			if (op_fde) begin
				dlo_q[d_hline] <= 1'b0;
				dhi_q[d_hline] <= 1'b0;
			end
			if (wb_end | dfill_end) begin
				dlo_q[lidx(set_q, way_q)] <= 1'b0;
				dhi_q[lidx(set_q, way_q)] <= 1'b0;
			end
			if (d_st_hit) begin
				if (d_va[4]) begin
					dhi_q[d_hline] <= 1'b1;
				end else begin
					dlo_q[d_hline] <= 1'b1;
				end
			end
		end
	end

	// ********************************
	// External bus master
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 32'h0;
			mem_words_q <= 4'h0;
			mem_wdata_q <= 32'h0;
			mem_be_q <= 4'h0;
			mem_buf_q <= 1'b0;
			cnt_q <= 3'h0;
			last_q <= 3'h0;
		end else if (mem_ld) begin
			mem_req_q <= 1'b1;
			mem_we_q <= ld_we;
			mem_addr_q <= ld_addr;
			mem_words_q <= ld_words;
			mem_wdata_q <= ld_wdata;
			mem_be_q <= (d_single | i_single) ? (d_go ? d_be : 4'hf) : 4'hf;
			mem_buf_q <= ld_buf;
			cnt_q <= start_wb ? wb_k0 : 3'h0;
			last_q <= ld_last;
		end else if (beat) begin
			if (cnt_q == last_q) begin
				mem_req_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q + 3'h1;
				mem_wdata_q <= ddata[widx(set_q, way_q, cnt_q + 3'h1)];
			end
		end
	end

	// ********************************
	// Sequencer and core answers
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			word_q <= 3'h0;
			set_q <= '0;
			way_q <= '0;
			pa_q <= 27'h0;
			wb_op_q <= 1'b0;
			cap_q <= 32'h0;
			op_done_q <= 1'b0;
			if_ack_q <= 1'b0;
			if_rdata_q <= 32'h0;
			d_ack_q <= 1'b0;
			d_rdata_q <= 32'h0;
		end else begin
			if_ack_q <= 1'b0;
			d_ack_q <= 1'b0;
			op_done_q <= 1'b0;
			if (beat & (cnt_q == word_q)) begin
				cap_q <= mem_rdata;
			end
			case (st_q)
				ST_IDLE: begin
					set_q <= (d_go | op_act) ? dk_set : ik_set;
					way_q <= start_wb ? wb_way : d_go ? dc_vway : ic_vway;
					word_q <= d_go ? d_va[4:2] : if_va[4:2];
					pa_q <= d_pa[31:5];
					wb_op_q <= op_act;
					op_done_q <= op_act & ~op_cde;
					if (d_go & dc_hit) begin
						d_ack_q <= 1'b1;
						d_rdata_q <= ddata[widx(dk_set, dc_hway, d_va[4:2])];
					end
					if (i_go & ic_hit) begin
						if_ack_q <= 1'b1;
						if_rdata_q <= idata[widx(ik_set, ic_hway, if_va[4:2])];
					end
					if (start_wb) begin
						st_q <= ST_WB;
					end else if (i_alloc) begin
						st_q <= ST_IFILL;
					end else if (start_dfill) begin
						st_q <= ST_DFILL;
					end else if (i_single) begin
						st_q <= ST_ISINGLE;
					end else if (d_single) begin
						st_q <= d_we ? ST_DWRITE : ST_DSINGLE;
					end
				end
				ST_WB: begin
					if (wb_end) begin
						op_done_q <= wb_op_q;
						st_q <= ST_IDLE;
					end
				end
				ST_IFILL: begin
					if (ifill_end) begin
						if_ack_q <= 1'b1;
						if_rdata_q <= fill_word;
						st_q <= ST_IDLE;
					end
				end
				ST_DFILL: begin
					if (dfill_end) begin
						d_ack_q <= 1'b1;
						d_rdata_q <= fill_word;
						st_q <= ST_IDLE;
					end
				end
				ST_ISINGLE: begin
					if (beat) begin
						if_ack_q <= 1'b1;
						if_rdata_q <= mem_rdata;
						st_q <= ST_IDLE;
					end
				end
				ST_DSINGLE: begin
					if (beat) begin
						d_ack_q <= 1'b1;
						d_rdata_q <= mem_rdata;
						st_q <= ST_IDLE;
					end
				end
				ST_DWRITE: begin
					if (beat) begin
						d_ack_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign if_ack = if_ack_q;
	assign if_rdata = if_rdata_q;
	assign d_ack = d_ack_q;
	assign d_rdata = d_rdata_q;
	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_words = mem_words_q;
	assign mem_wdata = mem_wdata_q;
	assign mem_be = mem_be_q;
	assign mem_bufferable = mem_buf_q;
endmodule

/* src/vcache_cfg.svh */
`ifndef VCACHE_CFG_SVH
`define VCACHE_CFG_SVH

// ********************************
// Register offsets (byte addresses)
// ********************************
`define OFS_CTRL 8'h00
`define OFS_CACHEOP 8'h04
`define OFS_STATUS 8'h08

// ********************************
// Control register fields
// ********************************
`define CTRL_MMU_BIT 0
`define CTRL_DC_BIT 2
`define CTRL_IC_BIT 12
`define CTRL_WMASK 32'h0000_1005
`define CTRL_RESET 32'h0000_0000

// ********************************
// Cache operation codes, data bits [2:0]
// ********************************
`define OP_FLUSH_ID 3'h1
`define OP_FLUSH_I 3'h2
`define OP_FLUSH_D 3'h3
`define OP_FLUSH_DE 3'h4
`define OP_CLEAN_DE 3'h5

// ********************************
// Transfer lengths
// ********************************
`define LINE_LAST 3'h7
`define HALF_LAST 3'h3
`define HALF_FIRST 3'h4
`define WORDS_LINE 4'h8
`define WORDS_HALF 4'h4
`define WORDS_ONE 4'h1

`endif

/* src/vcache_pkg.sv */
package vcache_pkg;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_IFILL = 7'h02,
		ST_ISINGLE = 7'h04,
		ST_DFILL = 7'h08,
		ST_DSINGLE = 7'h10,
		ST_DWRITE = 7'h20,
		ST_WB = 7'h40
	} fsm_state_t;

endpackage

/* src/way_lookup.sv */
`timescale 1ns/1ps
module way_lookup
	import vcache_pkg::*;
#(
	parameter int SETS = 16,
	parameter int WAYS = 32,
	parameter int TAGW = 23
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [$clog2(SETS)-1:0] lk_set,
	input wire logic [TAGW-1:0] lk_tag,
	output logic hit,
	output logic [$clog2(WAYS)-1:0] hit_way,
	output logic [$clog2(WAYS)-1:0] vic_way,
	output logic vic_valid,
	input wire logic wr_en,
	input wire logic [$clog2(SETS)-1:0] wr_set,
	input wire logic [$clog2(WAYS)-1:0] wr_way,
	input wire logic [TAGW-1:0] wr_tag,
	input wire logic inv_one,
	input wire logic [$clog2(WAYS)-1:0] inv_way,
	input wire logic inv_all
);
	localparam int SW = $clog2(SETS);
	localparam int WW = $clog2(WAYS);

	if ((1 << SW) != SETS || (1 << WW) != WAYS || SW < 1 || WW < 1) begin : g_bad
		$error("way_lookup: SETS and WAYS must be powers of two above one");
	end

	logic [TAGW-1:0] tag_mem [SETS*WAYS];
	logic [SETS*WAYS-1:0] valid_q;
	logic [WW-1:0] rr_q [SETS];

	always_comb begin
		hit = 1'b0;
		hit_way = '0;
		for (int w = 0; w < WAYS; w++) begin
			if (valid_q[{lk_set, w[WW-1:0]}] && tag_mem[{lk_set, w[WW-1:0]}] == lk_tag) begin
				hit = 1'b1;
				hit_way = w[WW-1:0];
			end
		end
	end

	// Round-robin victim per set
	assign vic_way = rr_q[lk_set];
	assign vic_valid = valid_q[{lk_set, rr_q[lk_set]}];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			tag_mem[{wr_set, wr_way}] <= wr_tag;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			valid_q <= '0;
			for (int s = 0; s < SETS; s++) begin
				rr_q[s] <= '0;
			end
		end else if (inv_all) begin
			valid_q <= '0;
		end else begin
			if (inv_one) begin
				valid_q[{lk_set, inv_way}] <= 1'b0;
			end
			if (wr_en) begin
				valid_q[{wr_set, wr_way}] <= 1'b1;
				rr_q[wr_set] <= WW'(wr_way + 1'b1);
			end
		end
	end
endmodule

/* src/cache_ctrl_regs.sv */
`timescale 1ns/1ps
`include "vcache_cfg.svh"
module cache_ctrl_regs
	import vcache_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mmu_en,
	output logic dc_en,
	output logic ic_en,
	output logic op_valid,
	output logic [2:0] op_code,
	output logic [31:0] op_va,
	input wire logic op_done,
	input wire logic engine_busy
);
	logic [31:0] ctrl_q;
	logic [31:0] prdata_q;
	logic [31:0] op_va_q;
	logic [2:0] op_code_q;
	logic pready_q;
	logic pslverr_q;
	logic op_valid_q;

	wire acc = psel & penable & ~pready_q;
	wire fin = psel & penable & pready_q;
	wire is_ctrl = (paddr == `OFS_CTRL);
	wire is_op = (paddr == `OFS_CACHEOP);
	wire is_stat = (paddr == `OFS_STATUS);
	wire mapped = is_ctrl | is_op | is_stat;
	// A second operation waits until the engine has finished the first
	wire hold = acc & pwrite & is_op & op_valid_q;
	wire [31:0] rd_val = is_ctrl ? ctrl_q : is_stat ? {30'h0, engine_busy, op_valid_q} : 32'h0;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_q <= `CTRL_RESET;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			op_valid_q <= 1'b0;
			op_code_q <= 3'h0;
			op_va_q <= 32'h0;
		end else begin
			pready_q <= acc & ~hold;
			pslverr_q <= acc & ~hold & ~mapped;
			prdata_q <= (acc & ~pwrite) ? rd_val : 32'h0;
			if (fin & pwrite & is_ctrl) begin
				ctrl_q <= pwdata & `CTRL_WMASK;
			end
			if (fin & pwrite & is_op) begin
				op_valid_q <= 1'b1;
				op_code_q <= pwdata[2:0];
				op_va_q <= pwdata;
			end else if (op_done) begin
				op_valid_q <= 1'b0;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign mmu_en = ctrl_q[`CTRL_MMU_BIT];
	assign dc_en = ctrl_q[`CTRL_DC_BIT];
	assign ic_en = ctrl_q[`CTRL_IC_BIT];
	assign op_valid = op_valid_q;
	assign op_code = op_code_q;
	assign op_va = op_va_q;
endmodule

/* testbench/vcache_properties.sv */
`timescale 1ns/1ps
module vcache_checker (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic if_ack,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_words,
	input wire logic mem_bufferable,
	input wire logic mem_ack,
	input wire logic d_ack
);
	// ********
	// Port rules
	// ********
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	a_apb_answer: assert property (psel && $rose(penable) |-> ##[1:40] pready)
		else $error("apb unanswered");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_reset_quiet: assert property ($rose(nrst) |-> !mem_req && !if_ack && !d_ack)
		else $error("busy after reset");
	a_fetch_pulse: assert property (if_ack |=> !if_ack)
		else $error("fetch ack held");
	a_read_len: assert property ($rose(mem_req) && !mem_we |-> mem_words == 4'h1 || mem_words == 4'h8)
		else $error("bad read length");
	a_write_len: assert property ($rose(mem_req) && mem_we |-> mem_words inside {4'h1, 4'h4, 4'h8})
		else $error("bad write length");
	a_copyback_buf: assert property (mem_req && mem_we && mem_words != 4'h1 |-> mem_bufferable)
		else $error("copyback unbuffered");
	a_fields_hold: assert property (mem_req && $past(mem_req) |-> $stable(mem_addr) && $stable(mem_words))
		else $error("burst fields moved");
	a_req_drop: assert property ($fell(mem_req) |-> $past(mem_ack))
		else $error("burst ended early");
	c_fill: cover property ($rose(mem_req) && mem_words == 4'h8);
	c_copyback: cover property ($rose(mem_req) && mem_we && mem_words == 4'h4);
	c_slverr: cover property (pslverr);
endmodule
bind virtual_icache_dcache vcache_checker u_chk (.clk_sys, .nrst, .psel, .penable, .pready, .pslverr, .if_ack,
	.mem_req, .mem_we, .mem_addr, .mem_words, .mem_bufferable, .mem_ack, .d_ack);

/* testbench/far_memory.sv */
`timescale 1ns/1ps
module far_memory (
	input wire logic clk_sys,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_words,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_bufferable,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] m [logic [31:0]];
	logic [31:0] a;
	logic [31:0] wr_addr = 32'h0;
	logic wr_buf = 1'b0;
	int gap = 0, n_rd1 = 0, n_rd8 = 0, n_wr = 0, wr_words = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		forever begin
			@(posedge clk_sys);
			if (mem_req) begin
				for (int i = 0; i < int'(mem_words); i++) begin
					a = mem_addr + 32'(4 * i);
					repeat (gap) begin
						mem_ack <= 1'b0;
						mem_rdata <= ~mem_rdata;
						@(posedge clk_sys);
					end
					mem_ack <= 1'b1;
					mem_rdata <= m.exists(a) ? m[a] : a ^ 32'h3c5a_0000;
					@(posedge clk_sys);
					if (mem_we) m[a] = mem_wdata;
				end
				// Inverted word so a stale read never looks right
				mem_ack <= 1'b0;
				mem_rdata <= ~mem_rdata;
				if (mem_we) begin
					n_wr++;
					wr_words = int'(mem_words);
					wr_addr = mem_addr;
					wr_buf = mem_bufferable;
				end else if (mem_words == 4'h8) n_rd8++;
				else n_rd1++;
			end
		end
	end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "vcache_cfg.svh"
module tb;
	logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, if_req = 1'b0;
	logic if_cacheable = 1'b0, d_req = 1'b0, d_we = 1'b0, d_cacheable = 1'b0, d_bufferable = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [3:0] d_be = 4'hf;
	logic [31:0] pwdata = 32'h0, if_va = 32'h0, if_pa = 32'h0, d_va = 32'h0, d_pa = 32'h0, d_wdata = 32'h0;
	logic pready, pslverr, if_ack, d_ack, mem_req, mem_we, mem_bufferable, mem_ack;
	logic [3:0] mem_words, mem_be;
	logic [31:0] prdata, if_rdata, d_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] qi[$], qd[$], qp[$], seed = 32'h64ac, r1, r2;
	logic qe[$];
	int n_errors = 0, checks = 0;

	virtual_icache_dcache u_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .if_req, .if_va, .if_pa, .if_cacheable, .if_ack, .if_rdata, .d_req, .d_we, .d_be, .d_va, .d_pa,
		.d_wdata, .d_cacheable, .d_bufferable, .d_ack, .d_rdata, .mem_req, .mem_we, .mem_addr, .mem_words,
		.mem_wdata, .mem_be, .mem_bufferable, .mem_ack, .mem_rdata);
	far_memory u_mem (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_words, .mem_wdata, .mem_bufferable,
		.mem_ack, .mem_rdata);

	always #25 clk_sys = ~clk_sys;

	// ********
	// Helpers
	// ********
	function automatic logic [31:0] mv(input logic [31:0] a);
		return a ^ 32'h3c5a_0000;
	endfunction
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int rd_tot();
		return u_mem.n_rd1 + u_mem.n_rd8;
	endfunction
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		qe.push_back(a > 8'h08);
		if (!w) qp.push_back(e);
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic op(input logic [2:0] c, input logic [31:0] va);
		apb(1'b1, `OFS_CACHEOP, {va[31:3], c}, 32'h0);
	endtask
	task automatic fetch(input logic [31:0] a, input logic c, input logic [31:0] e);
		if_req <= 1'b1;
		if_va <= a;
		if_pa <= a;
		if_cacheable <= c;
		qi.push_back(e);
		do @(posedge clk_sys); while (if_ack !== 1'b1);
		if_req <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Store data doubles as the expected load value
	task automatic dacc(input logic w, input logic [31:0] a, input logic c, input logic [31:0] e);
		d_req <= 1'b1;
		d_we <= w;
		d_va <= a;
		d_pa <= a;
		d_cacheable <= c;
		d_bufferable <= seed[3];
		d_wdata <= e;
		if (!w) qd.push_back(e);
		do @(posedge clk_sys); while (d_ack !== 1'b1);
		d_req <= 1'b0;
		@(posedge clk_sys);
	endtask

	always @(posedge clk_sys) begin
		if (pready === 1'b1) begin
			check("pslverr", pslverr, qe.pop_front());
			if (!pwrite) check("prdata", prdata, qp.pop_front());
		end
		if (if_ack === 1'b1) check("if_rdata", if_rdata, qi.pop_front());
		if (d_ack === 1'b1 && !d_we) check("d_rdata", d_rdata, qd.pop_front());
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		$display("watchdog expired");
		conclude();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, `OFS_CTRL, 32'h0, `CTRL_RESET);
		apb(1'b0, `OFS_STATUS, 32'h0, 32'h0);
		apb(1'b0, `OFS_CACHEOP, 32'h0, 32'h0);
		apb(1'b0, 8'h0c, 32'h0, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'hffff_ffff, 32'h0);
		apb(1'b0, `OFS_CTRL, 32'h0, `CTRL_WMASK);
		$display("test registers done");
		u_mem.gap = int'(xs() % 32'h3);
		apb(1'b1, `OFS_CTRL, 32'h1000, 32'h0);
		fetch(32'h1004, 1'b0, mv(32'h1004));
		fetch(32'h101c, 1'b1, mv(32'h101c));
		check("line fills", u_mem.n_rd8, 1);
		check("reads", rd_tot(), 1);
		apb(1'b1, `OFS_CTRL, 32'h1001, 32'h0);
		fetch(32'h2000, 1'b0, mv(32'h2000));
		fetch(32'h2000, 1'b0, mv(32'h2000));
		check("single reads", u_mem.n_rd1, 2);
		apb(1'b1, `OFS_CTRL, 32'h0001, 32'h0);
		fetch(32'h1008, 1'b1, mv(32'h1008));
		check("reads", rd_tot(), 3);
		fetch(32'h3000, 1'b1, mv(32'h3000));
		fetch(32'h3000, 1'b1, mv(32'h3000));
		check("reads", rd_tot(), 5);
		apb(1'b1, `OFS_CTRL, 32'h1001, 32'h0);
		op(`OP_FLUSH_I, 32'h0);
		fetch(32'h1008, 1'b1, mv(32'h1008));
		check("reads", rd_tot(), 6);
		$display("test icache done");
		u_mem.gap = int'(xs() % 32'h3);
		apb(1'b1, `OFS_CTRL, 32'h1005, 32'h0);
		dacc(1'b0, 32'h4008, 1'b1, mv(32'h4008));
		check("reads", rd_tot(), 7);
		r1 = xs();
		dacc(1'b1, 32'h4008, 1'b1, r1);
		dacc(1'b0, 32'h4008, 1'b1, r1);
		check("writes", u_mem.n_wr, 0);
		op(`OP_CLEAN_DE, 32'h4000);
		dacc(1'b0, 32'h400c, 1'b0, mv(32'h400c));
		check("writes", u_mem.n_wr, 1);
		check("wb words", u_mem.wr_words, 4);
		check("wb addr", u_mem.wr_addr, 32'h4000);
		check("wb buf", u_mem.wr_buf, 1);
		dacc(1'b0, 32'h5000, 1'b0, mv(32'h5000));
		dacc(1'b0, 32'h5000, 1'b0, mv(32'h5000));
		check("reads", rd_tot(), 9);
		$display("test dcache done");
		u_mem.gap = int'(xs() % 32'h3);
		r2 = xs();
		dacc(1'b1, 32'h4010, 1'b1, r2);
		op(`OP_FLUSH_D, 32'h0);
		dacc(1'b0, 32'h4010, 1'b1, mv(32'h4010));
		dacc(1'b0, 32'h4008, 1'b1, r1);
		check("writes", u_mem.n_wr, 1);
		dacc(1'b1, 32'h4000, 1'b1, r2);
		op(`OP_FLUSH_DE, 32'h4000);
		dacc(1'b0, 32'h4000, 1'b1, mv(32'h4000));
		check("writes", u_mem.n_wr, 1);
		check("reads", rd_tot(), 11);
		apb(1'b1, `OFS_CTRL, 32'h1001, 32'h0);
		dacc(1'b1, 32'h4004, 1'b1, r1);
		dacc(1'b0, 32'h4004, 1'b1, r1);
		dacc(1'b0, 32'h6000, 1'b1, mv(32'h6000));
		dacc(1'b0, 32'h6000, 1'b1, mv(32'h6000));
		check("reads", rd_tot(), 13);
		op(`OP_CLEAN_DE, 32'h4000);
		op(`OP_FLUSH_ID, 32'h0);
		fetch(32'h1008, 1'b1, mv(32'h1008));
		check("reads", rd_tot(), 14);
		check("writes", u_mem.n_wr, 2);
		dacc(1'b0, 32'h4004, 1'b1, r1);
		dacc(1'b1, 32'h1008, 1'b1, r2);
		check("writes", u_mem.n_wr, 3);
		check("wb words", u_mem.wr_words, 1);
		check("wb addr", u_mem.wr_addr, 32'h1008);
		fetch(32'h1008, 1'b1, mv(32'h1008));
		dacc(1'b0, 32'h1008, 1'b0, r2);
		check("reads", rd_tot(), 16);
		$display("test maintenance done");
		conclude();
	end
endmodule
